// file: logic/src_pkg.sv
// Package for the system reset controller: states, timing, carriers.
// Assumes a 10 MHz core clock; all other files use src_pkg::name.
package src_pkg;

    // Core clock period in ns
    localparam int unsigned CLK_PERIOD_NS = 100;

    // Least low time of the external reset pin, in us
    localparam int unsigned PIN_LOW_MIN_US = 10;
    localparam int unsigned PIN_LOW_MIN_CYC =
        (PIN_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Default oscillation stabilisation and reset processing, in cycles
    localparam int unsigned OSC_STAB_CYC_DEF  = 64;
    localparam int unsigned RST_PROC_CYC_DEF  = 4;

    // Reset vector: low byte then high byte
    localparam logic [15:0] VEC_LO_ADDR = 16'h0000;
    localparam logic [15:0] VEC_HI_ADDR = 16'h0001;

    // Cause bit positions in the cause record
    localparam int unsigned CAUSE_PIN = 0;
    localparam int unsigned CAUSE_WDT = 1;
    localparam int unsigned CAUSE_POC = 2;
    localparam int unsigned CAUSE_LVD = 3;
    localparam int unsigned N_SRC     = 4;

    typedef enum logic [2:0] {
        ST_RESET  = 3'b000,
        ST_STAB   = 3'b001,
        ST_VEC_LO = 3'b011,
        ST_VEC_HI = 3'b010,
        ST_RUN    = 3'b110
    } src_state_t;

    // Oscillator and external clock controls while reset is applied
    typedef struct packed {
        logic main_crystal_en;
        logic sub_crystal_en;
        logic int_hs_osc_en;
        logic int_ls_osc_en;
        logic ext_clk_accept;
    } src_osc_ctl_t;

    // Vector fetch request toward program memory
    typedef struct packed {
        logic        req;
        logic [15:0] addr;
    } src_fetch_t;

endpackage

// file: logic/src_reset_ctrl.sv
// System reset controller: merges four reset sources, holds pins in
// high impedance, stops oscillators, then fetches the reset vector.
// Assumes CORE_CLK is the internal high-speed oscillator after release
// and that detector levels arrive from other domains (synchronised here).
//
// What this block does
// - Reset from pin, watchdog, power-on, low voltage
// - Start execution at vector 0000H/0001H
// - Every source gives the same reset state
// - Pins high impedance in reset and stabilisation
// - Pin reset lasts while pin low
// - Watchdog reset releases by itself
// - Detector reset releases when supply recovers
// - Oscillators stopped, external clock ignored in reset
// - Stop state kept during reset, pins released
`timescale 1ns/100ps

module src_reset_ctrl #(
    parameter int unsigned OSC_STAB_CYC = src_pkg::OSC_STAB_CYC_DEF,
    parameter int unsigned RST_PROC_CYC = src_pkg::RST_PROC_CYC_DEF
) (
    input  wire logic                 CORE_CLK,
    input  wire logic                 RST,
    input  wire logic                 CLK_EN,
    input  wire logic                 RESET_PIN_N,
    input  wire logic                 WDT_LOOP_DET,
    input  wire logic                 POC_BELOW_THR,
    input  wire logic                 LVD_BELOW_THR,
    input  wire logic                 STOP_MODE_IN,
    input  wire logic [7:0]           VEC_DATA,
    output logic                      SYS_RST,
    output logic                      PIN_HIZ,
    output src_pkg::src_osc_ctl_t     OSC_CTL,
    output logic                      STOP_HELD,
    output src_pkg::src_fetch_t       VEC_FETCH,
    output logic                      PC_LOAD,
    output logic [15:0]               PC_VALUE,
    output logic [src_pkg::N_SRC-1:0] RST_CAUSE
);

    // Both counts load a 16-bit down counter, so zero cannot be served
    if (OSC_STAB_CYC < 1 || OSC_STAB_CYC > 65535 ||
        RST_PROC_CYC < 1 || RST_PROC_CYC > 65535)
    begin : g_bad_cycles
        $error("src_reset_ctrl: cycle counts out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // Source synchronisers, one per source

    logic [src_pkg::N_SRC-1:0] src_raw;
    logic [src_pkg::N_SRC-1:0] sync1_q;
    logic [src_pkg::N_SRC-1:0] sync2_q;

    // Pin is active low; detectors are active high
    assign src_raw[src_pkg::CAUSE_PIN] = ~RESET_PIN_N;
    assign src_raw[src_pkg::CAUSE_WDT] = WDT_LOOP_DET;
    assign src_raw[src_pkg::CAUSE_POC] = POC_BELOW_THR;
    assign src_raw[src_pkg::CAUSE_LVD] = LVD_BELOW_THR;

    // Synchronisers run regardless of CLK_EN so a reset is never missed
    genvar gi;
    generate
        for (gi = 0; gi < src_pkg::N_SRC; gi++)
        begin : g_sync
            always_ff @(posedge CORE_CLK or posedge RST)
            begin
                if (RST)
                begin
                    sync1_q[gi] <= 1'b1;
                    sync2_q[gi] <= 1'b1;
                end
                else
                begin
                    sync1_q[gi] <= src_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    logic stop_sync1_q;
    logic stop_sync2_q;

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            stop_sync1_q <= 1'b0;
            stop_sync2_q <= 1'b0;
        end
        else
        begin
            stop_sync1_q <= STOP_MODE_IN;
            stop_sync2_q <= stop_sync1_q;
        end
    end

    // Any source asserts reset; all share one path and one state
    logic any_src;
    assign any_src = |sync2_q;

    ////////////////////////////////////////////////////////////////////
    // Sequencer

    src_pkg::src_state_t state_q, state_d;
    logic [15:0]               cnt_q, cnt_d;
    logic [7:0]                vlo_q, vlo_d;
    logic [src_pkg::N_SRC-1:0] cause_q, cause_d;
    logic                      stop_held_q, stop_held_d;
    logic                      pc_load_q, pc_load_d;
    logic [15:0]               pc_q, pc_d;

    always_comb
    begin
        state_d     = state_q;
        cnt_d       = cnt_q;
        vlo_d       = vlo_q;
        cause_d     = cause_q | sync2_q;
        stop_held_d = stop_held_q;
        pc_load_d   = 1'b0;
        pc_d        = pc_q;
        if (any_src)
        begin
            // Held while any source stays active; release when all clear
            state_d = src_pkg::ST_RESET;
            cnt_d   = 16'(OSC_STAB_CYC - 1);
            // Stop contents kept through reset input
            if (state_q == src_pkg::ST_RUN)
                stop_held_d = stop_sync2_q;
        end
        else
        begin
            case (state_q)
                src_pkg::ST_RESET:
                begin
                    state_d = src_pkg::ST_STAB;
                    cnt_d   = 16'(OSC_STAB_CYC - 1);
                end
                src_pkg::ST_STAB:
                begin
                    if (cnt_q == 16'h0000)
                    begin
                        state_d = src_pkg::ST_VEC_LO;
                        cnt_d   = 16'(RST_PROC_CYC - 1);
                    end
                    else
                        cnt_d = cnt_q - 16'h0001;
                end
                src_pkg::ST_VEC_LO:
                begin
                    if (cnt_q == 16'h0000)
                    begin
                        vlo_d   = VEC_DATA;
                        state_d = src_pkg::ST_VEC_HI;
                    end
                    else
                        cnt_d = cnt_q - 16'h0001;
                end
                src_pkg::ST_VEC_HI:
                begin
                    pc_d        = {VEC_DATA, vlo_q};
                    pc_load_d   = 1'b1;
                    stop_held_d = 1'b0;
                    state_d     = src_pkg::ST_RUN;
                end
                // Cause stays visible until one cycle after vector load
                src_pkg::ST_RUN:
                    cause_d = '0;
                default:
                    state_d = src_pkg::ST_RESET;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            state_q     <= src_pkg::ST_RESET;
            cnt_q       <= 16'h0000;
            vlo_q       <= 8'h00;
            cause_q     <= '0;
            stop_held_q <= 1'b0;
            pc_load_q   <= 1'b0;
            pc_q        <= 16'h0000;
        end
        else if (CLK_EN || any_src)
        begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            vlo_q       <= vlo_d;
            cause_q     <= cause_d;
            stop_held_q <= stop_held_d;
            pc_load_q   <= pc_load_d;
            pc_q        <= pc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registered outputs

    logic                   in_rst_d;
    logic                   hiz_d;
    logic                   fetch_d;
    logic [15:0]            faddr_d;
    src_pkg::src_osc_ctl_t  osc_d;

    always_comb
    begin
        in_rst_d = any_src || state_d != src_pkg::ST_RUN;
        hiz_d    = any_src || state_d == src_pkg::ST_RESET ||
                   state_d == src_pkg::ST_STAB;
        fetch_d  = !any_src && (state_d == src_pkg::ST_VEC_LO ||
                                state_d == src_pkg::ST_VEC_HI);
        faddr_d  = (state_d == src_pkg::ST_VEC_HI) ?
                   src_pkg::VEC_HI_ADDR : src_pkg::VEC_LO_ADDR;
        // Every oscillator off while a source is active
        osc_d.main_crystal_en = !any_src;
        osc_d.sub_crystal_en  = !any_src;
        osc_d.int_hs_osc_en   = !any_src;
        osc_d.int_ls_osc_en   = !any_src;
        osc_d.ext_clk_accept  = !any_src;
    end

    // Release is one flop edge, so all logic leaves reset together
    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            SYS_RST   <= 1'b1;
            PIN_HIZ   <= 1'b1;
            OSC_CTL   <= '0;
            VEC_FETCH <= '0;
        end
        else if (CLK_EN || any_src)
        begin
            SYS_RST        <= in_rst_d;
            PIN_HIZ        <= hiz_d;
            OSC_CTL        <= osc_d;
            VEC_FETCH.req  <= fetch_d;
            VEC_FETCH.addr <= faddr_d;
        end
    end

    assign STOP_HELD = stop_held_q;
    assign PC_LOAD   = pc_load_q;
    assign PC_VALUE  = pc_q;
    assign RST_CAUSE = cause_q;

endmodule

// file: testbench/src_far_side.sv
// Far side: reset sources and the program memory holding the vector.
// Assumes set_src is called by the bench; changes land at falling edges.
`timescale 1ns/100ps
module src_far_side #(
    parameter logic [7:0] VEC_LO = 8'h34,
    parameter logic [7:0] VEC_HI = 8'h12
) (
    input  wire logic                CORE_CLK,
    input  wire src_pkg::src_fetch_t VEC_FETCH,
    output logic                     RESET_PIN_N,
    output logic                     WDT_LOOP_DET,
    output logic                     POC_BELOW_THR,
    output logic                     LVD_BELOW_THR,
    output logic [7:0]               VEC_DATA
);
logic [7:0] last_q = 8'h00;
logic [3:0] src = 4'h0;
assign RESET_PIN_N = !src[0];
assign WDT_LOOP_DET = src[1];
assign POC_BELOW_THR = src[2];
assign LVD_BELOW_THR = src[3];
task automatic set_src(input int unsigned i, input logic on);
    @(negedge CORE_CLK);
    src[i] = on;
endtask
// Unaddressed memory shows a changing value, never the last byte
always_comb
    if (VEC_FETCH.req && VEC_FETCH.addr == src_pkg::VEC_LO_ADDR)
        VEC_DATA = VEC_LO;
    else if (VEC_FETCH.req && VEC_FETCH.addr == src_pkg::VEC_HI_ADDR)
        VEC_DATA = VEC_HI;
    else
        VEC_DATA = ~last_q;
always_ff @(posedge CORE_CLK)
    last_q <= VEC_DATA;
endmodule

// file: testbench/src_reset_ctrl_asserts.sv
// Port checker for the system reset controller.
// Assumes one CORE_CLK domain and RST asynchronous, active high.
`timescale 1ns/100ps
module src_reset_ctrl_asserts #(
    parameter int unsigned OSC_STAB_CYC = src_pkg::OSC_STAB_CYC_DEF,
    parameter int unsigned RST_PROC_CYC = src_pkg::RST_PROC_CYC_DEF
) (
    input wire logic                  CORE_CLK,
    input wire logic                  RST,
    input wire logic                  RESET_PIN_N,
    input wire logic                  WDT_LOOP_DET,
    input wire logic                  POC_BELOW_THR,
    input wire logic                  LVD_BELOW_THR,
    input wire logic [7:0]            VEC_DATA,
    input wire logic                  SYS_RST,
    input wire logic                  PIN_HIZ,
    input wire src_pkg::src_osc_ctl_t OSC_CTL,
    input wire src_pkg::src_fetch_t   VEC_FETCH,
    input wire logic                  PC_LOAD,
    input wire logic [15:0]           PC_VALUE
);
logic       any_src;
logic       at_lo;
logic       at_hi;
logic [7:0] lo_cnt_q;
assign any_src = !RESET_PIN_N || WDT_LOOP_DET || POC_BELOW_THR
    || LVD_BELOW_THR;
assign at_lo = VEC_FETCH.req && VEC_FETCH.addr == src_pkg::VEC_LO_ADDR;
assign at_hi = VEC_FETCH.req && VEC_FETCH.addr == src_pkg::VEC_HI_ADDR;
// Counts the low-byte fetch cycles so the processing time is checked
always_ff @(posedge CORE_CLK or posedge RST)
    if (RST)
        lo_cnt_q <= 8'h00;
    else
        lo_cnt_q <= at_lo ? lo_cnt_q + 8'h01 : 8'h00;
default clocking @(posedge CORE_CLK); endclocking
default disable iff (RST);
property p_src_rst; any_src |-> ##3 SYS_RST && PIN_HIZ; endproperty
a_src_rst: assert property (p_src_rst) else $error("no reset");
property p_osc_off; any_src |-> ##3 OSC_CTL == 5'h00; endproperty
a_osc_off: assert property (p_osc_off) else $error("osc on");
property p_stab; $fell(PIN_HIZ) |-> SYS_RST ##[1:8] !SYS_RST; endproperty
a_stab: assert property (p_stab) else $error("hiz early");
property p_vec_hi; at_hi |=> PC_LOAD && !SYS_RST; endproperty
a_vec_hi: assert property (p_vec_hi) else $error("no load");
property p_lo_cnt; at_hi |-> lo_cnt_q == 8'(RST_PROC_CYC); endproperty
a_lo_cnt: assert property (p_lo_cnt) else $error("proc time");
property p_pc_val;
    PC_LOAD |-> PC_VALUE == {$past(VEC_DATA), $past(VEC_DATA, 2)};
endproperty
a_pc_val: assert property (p_pc_val) else $error("bad vector");
property p_pulse; PC_LOAD |=> !PC_LOAD && !SYS_RST; endproperty
a_pulse: assert property (p_pulse) else $error("load width");
property p_release; $fell(SYS_RST) |-> PC_LOAD && !PIN_HIZ; endproperty
a_release: assert property (p_release) else $error("release");
endmodule
bind src_reset_ctrl src_reset_ctrl_asserts #(.OSC_STAB_CYC(OSC_STAB_CYC),
    .RST_PROC_CYC(RST_PROC_CYC)) src_reset_ctrl_asserts_inst (
    .CORE_CLK(CORE_CLK), .RST(RST), .RESET_PIN_N(RESET_PIN_N),
    .WDT_LOOP_DET(WDT_LOOP_DET), .POC_BELOW_THR(POC_BELOW_THR),
    .LVD_BELOW_THR(LVD_BELOW_THR), .VEC_DATA(VEC_DATA), .SYS_RST(SYS_RST),
    .PIN_HIZ(PIN_HIZ), .OSC_CTL(OSC_CTL), .VEC_FETCH(VEC_FETCH),
    .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE));

// file: testbench/src_reset_ctrl_tb_top.sv
// Testbench for the system reset controller.
// Assumes a 10 MHz core clock; counts are shortened by parameters.
`timescale 1ns/100ps
module src_reset_ctrl_tb_top;
logic CORE_CLK = 1'b0;
logic RST = 1'b1;
logic CLK_EN = 1'b1;
logic STOP_MODE_IN = 1'b0;
logic RESET_PIN_N, WDT_LOOP_DET, POC_BELOW_THR, LVD_BELOW_THR;
logic SYS_RST, PIN_HIZ, STOP_HELD, PC_LOAD;
logic [7:0] VEC_DATA;
logic [15:0] PC_VALUE;
logic [3:0] RST_CAUSE;
src_pkg::src_osc_ctl_t OSC_CTL;
src_pkg::src_fetch_t VEC_FETCH;
int n_fail = 0;
int n_compared = 0;
always #50 CORE_CLK = ~CORE_CLK;
src_reset_ctrl #(.OSC_STAB_CYC(2), .RST_PROC_CYC(1)) src_reset_ctrl_inst (
    .CORE_CLK(CORE_CLK), .RST(RST), .CLK_EN(CLK_EN),
    .RESET_PIN_N(RESET_PIN_N), .WDT_LOOP_DET(WDT_LOOP_DET),
    .POC_BELOW_THR(POC_BELOW_THR), .LVD_BELOW_THR(LVD_BELOW_THR),
    .STOP_MODE_IN(STOP_MODE_IN), .VEC_DATA(VEC_DATA), .SYS_RST(SYS_RST),
    .PIN_HIZ(PIN_HIZ), .OSC_CTL(OSC_CTL), .STOP_HELD(STOP_HELD),
    .VEC_FETCH(VEC_FETCH), .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE),
    .RST_CAUSE(RST_CAUSE));
src_far_side src_far_side_inst (.CORE_CLK(CORE_CLK),
    .VEC_FETCH(VEC_FETCH), .RESET_PIN_N(RESET_PIN_N),
    .WDT_LOOP_DET(WDT_LOOP_DET), .POC_BELOW_THR(POC_BELOW_THR),
    .LVD_BELOW_THR(LVD_BELOW_THR), .VEC_DATA(VEC_DATA));
////////////////////////////////////////////////////////////////////////
task automatic check(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
        n_fail++;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
endtask
task automatic complete_run;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
task automatic wait_load;
    int k;
    k = 0;
    while (PC_LOAD !== 1'b1 && k < 200)
    begin
        @(negedge CORE_CLK);
        k++;
    end
    if (PC_LOAD !== 1'b1)
    begin
        n_fail++;
        complete_run;
    end
endtask
// Holds one source for len cycles, then follows the release to run
task automatic run_src(input int unsigned i, input int unsigned len);
    src_far_side_inst.set_src(i, 1'b1);
    repeat (len) @(negedge CORE_CLK);
    check("sys_rst", {15'h0000, SYS_RST}, 16'h0001);
    check("pin_hiz", {15'h0000, PIN_HIZ}, 16'h0001);
    check("osc_ctl", {11'h000, OSC_CTL}, 16'h0000);
    check("cause", {12'h000, RST_CAUSE}, 16'h0001 << i);
    check("stop", {15'h0000, STOP_HELD}, {15'h0000, STOP_MODE_IN});
    src_far_side_inst.set_src(i, 1'b0);
    wait_load;
    check("pc", PC_VALUE, 16'h1234);
    @(negedge CORE_CLK);
    check("run", {14'h0000, SYS_RST, PIN_HIZ}, 16'h0000);
    check("osc_run", {11'h000, OSC_CTL}, 16'h001f);
    check("cause_clr", {12'h000, RST_CAUSE}, 16'h0000);
    check("stop_clr", {15'h0000, STOP_HELD}, 16'h0000);
    $display("source %0d test done", i);
endtask
task automatic test_pin;
    run_src(0, 100);
endtask
task automatic test_detectors;
    for (int i = 1; i < 4; i++)
        run_src(i, 5);
endtask
// Second watchdog reset arrives during stabilisation
task automatic test_abort;
    src_far_side_inst.set_src(1, 1'b1);
    repeat (5) @(negedge CORE_CLK);
    src_far_side_inst.set_src(1, 1'b0);
    repeat (1) @(negedge CORE_CLK);
    run_src(1, 5);
endtask
// Sequence freezes while the enable is low, resumes when it returns
task automatic test_clk_en;
    CLK_EN = 1'b0;
    src_far_side_inst.set_src(3, 1'b1);
    repeat (5) @(negedge CORE_CLK);
    src_far_side_inst.set_src(3, 1'b0);
    repeat (10) @(negedge CORE_CLK);
    check("frozen", {14'h0000, SYS_RST, PIN_HIZ}, 16'h0003);
    CLK_EN = 1'b1;
    wait_load;
    check("pc_en", PC_VALUE, 16'h1234);
    @(negedge CORE_CLK);
    $display("clock enable test done");
endtask
task automatic test_stop;
    STOP_MODE_IN = 1'b1;
    repeat (4) @(negedge CORE_CLK);
    run_src(0, 100);
    STOP_MODE_IN = 1'b0;
endtask
initial
begin
    repeat (3) @(negedge CORE_CLK);
    RST = 1'b0;
    wait_load;
    @(negedge CORE_CLK);
    test_pin;
    test_detectors;
    test_abort;
    test_stop;
    test_clk_en;
    complete_run;
end
endmodule
